/* File: rtl/dcf_pkg.sv */
// shared constants and types of the dual-clock bus-matching fifo
package dcf_pkg;
  // word and lane widths
  localparam int DCF_DATA_W = 36;
  localparam int DCF_HALF_W = 18;
  localparam int DCF_BYTE_W = 9;
  // default depth is 2 to the power of this
  localparam int DCF_ADDR_W = 11;
  // index of the last lane of a word per side-two width, then the first lane and the lane step
  localparam logic [1:0] DCF_LAST_LONG = 2'h0;
  localparam logic [1:0] DCF_LAST_WORD = 2'h1;
  localparam logic [1:0] DCF_LAST_BYTE = 2'h3;
  localparam logic [1:0] DCF_LANE_FIRST = 2'h0;
  localparam logic [1:0] DCF_LANE_STEP = 2'h1;

  typedef enum logic {DCF_STANDARD, DCF_FALL_THROUGH} dcf_timing_e;
  typedef enum logic [1:0] {DCF_LONG, DCF_WORD, DCF_BYTE} dcf_width_e;

  // chip select and qualifier of one side travel together
  typedef struct packed {
    logic select_n;
    logic qualifier;
  } dcf_port_ctl_s;
endpackage : dcf_pkg

/* File: rtl/dcf_sync.sv */
// two-stage synchroniser for a gray-coded pointer
`timescale 1ns/1ns
`default_nettype none
module dcf_sync
  import dcf_pkg::*;
#(
  parameter int W = DCF_ADDR_W + 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : dcf_sync
`default_nettype wire

/* File: rtl/dcf_mem.sv */
// dual-clock storage array with registered read data
`timescale 1ns/1ns
`default_nettype none
module dcf_mem
  import dcf_pkg::*;
#(
  parameter int ADDR_W = DCF_ADDR_W,
  parameter int DATA_W = DCF_DATA_W
)
(
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] store [(1 << ADDR_W)];

  // array itself has no reset, contents are only read once written
  always_ff @(posedge wr_clk)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
  end

  // read data held until the next fetch
  always_ff @(posedge rd_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= '0;
    end
    else if (rd_en)
    begin
      rd_data <= store[rd_addr];
    end
  end
endmodule : dcf_mem
`default_nettype wire

/* File: rtl/dcf_fifo.sv */
// dual-clock fifo from side one to side two with side-two bus matching
`timescale 1ns/1ns
`default_nettype none
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int ADDR_W = DCF_ADDR_W
)
(
  input wire logic side_one_clock,
  input wire logic side_two_clock,
  input wire logic rst_n,
  input wire logic side_one_select_n,
  input wire logic side_one_qualifier,
  input wire logic [DCF_DATA_W-1:0] side_one_data_in,
  output logic [DCF_DATA_W-1:0] side_one_data_out,
  output logic side_one_data_oe,
  input wire logic side_two_select_n,
  input wire logic side_two_qualifier,
  input wire logic [DCF_DATA_W-1:0] side_two_data_in,
  output logic [DCF_DATA_W-1:0] side_two_data_out,
  output logic side_two_data_oe,
  input wire logic endian_timing_select,
  input wire logic narrow_bus_select,
  input wire logic byte_width_select,
  input wire logic [ADDR_W:0] near_full_threshold,
  input wire logic [ADDR_W:0] near_empty_threshold,
  output logic full_or_space_flag,
  output logic near_full_flag_n,
  output logic empty_or_valid_flag,
  output logic near_empty_flag_n
);
  localparam int PTR_W = ADDR_W + 1;
  localparam logic [PTR_W-1:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
  localparam logic [PTR_W-1:0] PTR_STEP = {{ADDR_W{1'b0}}, 1'b1};

  // side-one domain state
  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [PTR_W-1:0] gray;
    logic space;
    logic near_full_n;
    logic [DCF_DATA_W-1:0] dout;
    logic oe;
  } dcf_wr_s;

  // side-two domain state
  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [PTR_W-1:0] gray;
    logic pending;
    logic [DCF_DATA_W-1:0] hold;
    logic valid;
    logic [1:0] lane;
    logic [DCF_DATA_W-1:0] dout;
    logic oe;
    logic ready_flag;
    logic near_empty_n;
    logic cfg_done;
    logic big_endian;
    dcf_timing_e timing;
  } dcf_rd_s;

  dcf_wr_s wr;
  dcf_wr_s next_wr;
  dcf_rd_s rd;
  dcf_rd_s next_rd;
  dcf_port_ctl_s one_ctl;
  dcf_port_ctl_s two_ctl;
  logic [PTR_W-1:0] rd_gray_sync;
  logic [PTR_W-1:0] wr_gray_sync;
  logic [DCF_DATA_W-1:0] mem_q;
  logic do_write;
  logic do_fetch;

  function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : from_gray

  // pick one lane of a stored word, narrow data sits in the low bits
  function automatic logic [DCF_DATA_W-1:0] lane_sel(
    input logic [DCF_DATA_W-1:0] word,
    input logic [1:0] lane,
    input dcf_width_e width,
    input logic big
  );
    logic [1:0] k;
    logic [DCF_DATA_W-1:0] r;
    r = '0;
    k = lane;
    case (width)
      DCF_WORD:
      begin
        k = big ? (DCF_LAST_WORD - lane) : lane;
        r[DCF_HALF_W-1:0] = k[0] ? word[DCF_DATA_W-1 -: DCF_HALF_W] : word[DCF_HALF_W-1:0];
      end
      DCF_BYTE:
      begin
        k = big ? (DCF_LAST_BYTE - lane) : lane;
        r[DCF_BYTE_W-1:0] = word[k*DCF_BYTE_W +: DCF_BYTE_W];
      end
      default:
      begin
        r = word;
      end
    endcase
    return r;
  endfunction : lane_sel

  assign one_ctl = '{select_n: side_one_select_n, qualifier: side_one_qualifier};
  assign two_ctl = '{select_n: side_two_select_n, qualifier: side_two_qualifier};

  // side-two width, bus-match level is taken as static
  dcf_width_e width;
  logic [1:0] last_lane;
  always_comb
  begin
    width = DCF_LONG;
    last_lane = DCF_LAST_LONG;
    if (narrow_bus_select)
    begin
      width = byte_width_select ? DCF_BYTE : DCF_WORD;
      last_lane = byte_width_select ? DCF_LAST_BYTE : DCF_LAST_WORD;
    end
  end

  // gray pointers cross through two stages of the receiving clock
  dcf_sync #(.W(PTR_W)) u_rd_to_one (
    .clk(side_one_clock),
    .rst_n(rst_n),
    .d(rd.gray),
    .q(rd_gray_sync)
  );

  dcf_sync #(.W(PTR_W)) u_wr_to_two (
    .clk(side_two_clock),
    .rst_n(rst_n),
    .d(wr.gray),
    .q(wr_gray_sync)
  );

  dcf_mem #(.ADDR_W(ADDR_W), .DATA_W(DCF_DATA_W)) u_mem (
    .wr_clk(side_one_clock),
    .wr_en(do_write),
    .wr_addr(wr.ptr[ADDR_W-1:0]),
    .wr_data(side_one_data_in),
    .rd_clk(side_two_clock),
    .rst_n(rst_n),
    .rd_en(do_fetch),
    .rd_addr(rd.ptr[ADDR_W-1:0]),
    .rd_data(mem_q)
  );

  // side-one write path and its flags
  logic [PTR_W-1:0] rd_ptr_one;
  logic [PTR_W-1:0] free_now;
  logic [PTR_W-1:0] free_next;
  always_comb
  begin
    next_wr = wr;
    rd_ptr_one = from_gray(rd_gray_sync);
    // the synced read pointer lags, so free space is never overstated
    free_now = DEPTH - (wr.ptr - rd_ptr_one);
    do_write = !one_ctl.select_n && one_ctl.qualifier && (free_now != '0);
    if (do_write)
    begin
      next_wr.ptr = wr.ptr + PTR_STEP;
      next_wr.gray = to_gray(next_wr.ptr);
    end
    free_next = DEPTH - (next_wr.ptr - rd_ptr_one);
    next_wr.space = (free_next != '0);
    next_wr.near_full_n = !(free_next <= near_full_threshold);
    // side one only writes here, so its data pins stay released
    next_wr.dout = '0;
    next_wr.oe = 1'b0;
  end

  // flags of side one change on its own rising edge only
  always_ff @(posedge side_one_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr <= '{ptr: '0, gray: '0, space: 1'b1, near_full_n: 1'b1, dout: '0, oe: 1'b0};
    end
    else
    begin
      wr <= next_wr;
    end
  end

  // side-two read path, output stage and flags
  logic [PTR_W-1:0] wr_ptr_two;
  logic [PTR_W-1:0] stored_next;
  logic consume;
  logic last;
  logic stage_free;
  always_comb
  begin
    next_rd = rd;
    wr_ptr_two = from_gray(wr_gray_sync);
    consume = !two_ctl.select_n && two_ctl.qualifier && rd.valid;
    last = (rd.lane == last_lane);
    // a fetched word lands in the stage one edge later
    if (rd.pending)
    begin
      next_rd.hold = mem_q;
      next_rd.valid = 1'b1;
      next_rd.lane = DCF_LANE_FIRST;
      next_rd.pending = 1'b0;
    end
    else if (consume)
    begin
      if (last)
      begin
        next_rd.valid = 1'b0;
      end
      else
      begin
        next_rd.lane = rd.lane + DCF_LANE_STEP;
      end
    end
    // one word in flight at a time keeps the stage simple, at half rate for long words
    stage_free = !rd.valid || (consume && last);
    do_fetch = (wr_ptr_two != rd.ptr) && !rd.pending && stage_free;
    if (do_fetch)
    begin
      next_rd.pending = 1'b1;
      next_rd.ptr = rd.ptr + PTR_STEP;
      next_rd.gray = to_gray(next_rd.ptr);
    end
    // fall-through shows the lane at once, standard waits for a read
    if (rd.timing == DCF_FALL_THROUGH)
    begin
      next_rd.dout = lane_sel(next_rd.hold, next_rd.lane, width, rd.big_endian);
    end
    else if (consume)
    begin
      next_rd.dout = lane_sel(rd.hold, rd.lane, width, rd.big_endian);
    end
    next_rd.ready_flag = next_rd.valid;
    stored_next = wr_ptr_two - next_rd.ptr;
    next_rd.near_empty_n = !(stored_next <= near_empty_threshold);
    next_rd.oe = !two_ctl.select_n;
    // first edge after reset catches endian, later edges read timing
    if (!rd.cfg_done)
    begin
      next_rd.cfg_done = 1'b1;
      next_rd.big_endian = endian_timing_select;
    end
    else
    begin
      next_rd.timing = endian_timing_select ? DCF_STANDARD : DCF_FALL_THROUGH;
    end
  end

  // flags of side two change on its own rising edge only
  always_ff @(posedge side_two_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd <= '{ptr: '0, gray: '0, pending: 1'b0, hold: '0, valid: 1'b0, lane: DCF_LANE_FIRST,
              dout: '0, oe: 1'b0, ready_flag: 1'b0, near_empty_n: 1'b0, cfg_done: 1'b0,
              big_endian: 1'b0, timing: DCF_STANDARD};
    end
    else
    begin
      rd <= next_rd;
    end
  end

  assign side_one_data_out = wr.dout;
  assign side_one_data_oe = wr.oe;
  assign full_or_space_flag = wr.space;
  assign near_full_flag_n = wr.near_full_n;
  assign side_two_data_out = rd.dout;
  assign side_two_data_oe = rd.oe;
  assign empty_or_valid_flag = rd.ready_flag;
  assign near_empty_flag_n = rd.near_empty_n;
endmodule : dcf_fifo
`default_nettype wire

/* File: bench/dcf_fifo_properties.sv */
// port-level assertions of the dual-clock fifo
`timescale 1ns/1ns
`default_nettype none
module dcf_fifo_chk
  import dcf_pkg::*;
#(
  parameter int ADDR_W = DCF_ADDR_W
)
(
  input wire logic side_one_clock,
  input wire logic side_two_clock,
  input wire logic rst_n,
  input wire logic side_one_select_n,
  input wire logic side_one_qualifier,
  input wire logic side_one_data_oe,
  input wire logic side_two_select_n,
  input wire logic side_two_data_oe,
  input wire logic full_or_space_flag,
  input wire logic near_full_flag_n,
  input wire logic empty_or_valid_flag
);
  // six quiet edges drain any write still crossing over
  sequence s_quiet;
    (side_one_select_n && !empty_or_valid_flag) [*6];
  endsequence
  // side one only writes, so its pins never leave high impedance
  property p_one_hiz; @(posedge side_one_clock) disable iff (!rst_n) !side_one_data_oe; endproperty
  a_one_hiz: assert property (p_one_hiz) else $error("side one data driven");
  property p_two_hiz; @(posedge side_two_clock) disable iff (!rst_n) side_two_select_n [*2] |-> !side_two_data_oe; endproperty
  a_two_hiz: assert property (p_two_hiz) else $error("side two driven while deselected");
  property p_nf_full; @(posedge side_one_clock) disable iff (!rst_n) !full_or_space_flag |-> !near_full_flag_n; endproperty
  a_nf_full: assert property (p_nf_full) else $error("near full high while full");
  property p_wr_gate; @(posedge side_one_clock) disable iff (!rst_n) side_one_select_n |=> !$fell(full_or_space_flag); endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write taken while deselected");
  property p_wr_qual; @(posedge side_one_clock) disable iff (!rst_n) !side_one_qualifier |=> !$fell(full_or_space_flag); endproperty
  a_wr_qual: assert property (p_wr_qual) else $error("write taken without qualifier");
  property p_rd_gate; @(posedge side_two_clock) disable iff (!rst_n) side_two_select_n |=> !$fell(empty_or_valid_flag); endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read taken while deselected");
  property p_rst_one; @(posedge side_one_clock) disable iff (!rst_n) $rose(rst_n) |-> full_or_space_flag; endproperty
  a_rst_one: assert property (p_rst_one) else $error("no space after reset");
  property p_no_ghost; @(posedge side_two_clock) disable iff (!rst_n) s_quiet |=> !empty_or_valid_flag; endproperty
  a_no_ghost: assert property (p_no_ghost) else $error("data shown that was never written");
endmodule : dcf_fifo_chk
bind dcf_fifo dcf_fifo_chk #(.ADDR_W(ADDR_W)) u_chk (.side_one_clock(side_one_clock),
  .side_two_clock(side_two_clock), .rst_n(rst_n), .side_one_select_n(side_one_select_n),
  .side_one_qualifier(side_one_qualifier), .side_one_data_oe(side_one_data_oe),
  .side_two_select_n(side_two_select_n), .side_two_data_oe(side_two_data_oe),
  .full_or_space_flag(full_or_space_flag), .near_full_flag_n(near_full_flag_n),
  .empty_or_valid_flag(empty_or_valid_flag));
`default_nettype wire

/* File: bench/dcf_reader.sv */
// side-two reader standing in for the far-side controller
`timescale 1ns/1ns
`default_nettype none
module dcf_reader
  import dcf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic std,
  input wire logic want,
  input wire logic flag,
  input wire logic [DCF_DATA_W-1:0] data,
  output logic select_n,
  output logic qualifier,
  output logic got,
  output logic [DCF_DATA_W-1:0] q
);
  logic late;
  // request held until the flag lets an edge take it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      select_n <= 1'b1;
      qualifier <= 1'b0;
      got <= 1'b0;
      late <= 1'b0;
      q <= '0;
    end
    else
    begin
      got <= late;
      late <= 1'b0;
      if (late)
        q <= data;
      if (!select_n && qualifier && flag)
      begin
        select_n <= 1'b1;
        qualifier <= 1'b0;
        // standard timing loads the lane only after the read edge
        late <= std;
        got <= !std;
        if (!std)
          q <= data;
      end
      else if (want && select_n)
      begin
        select_n <= 1'b0;
        qualifier <= 1'b1;
      end
    end
  end
endmodule : dcf_reader
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the dual-clock fifo
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dcf_pkg::*;
  // bits: narrow, byte, big endian, standard timing
  localparam logic [3:0] CFG [4] = '{4'h2, 4'hA, 4'hC, 4'h1};
  localparam logic [35:0] W = 36'h987654321;
  logic clk = 1'b0, rst_n = 1'b0, s1n = 1'b1, q1 = 1'b0, ets = 1'b1, nb = 1'b0, bw = 1'b0, std = 1'b0;
  logic want = 1'b0;
  logic [35:0] d1 = '0;
  logic [35:0] d2, rq;
  logic fos, nfn, evf, nen, got, s2n, q2;
  int errors = 0, comparisons = 0, cycles = 0, n;
  // both sides share one clock, the coincident case
  dcf_fifo #(.ADDR_W(3)) DUT (.side_one_clock(clk), .side_two_clock(clk), .rst_n(rst_n),
    .side_one_select_n(s1n), .side_one_qualifier(q1), .side_one_data_in(d1), .side_one_data_out(),
    .side_one_data_oe(), .side_two_select_n(s2n), .side_two_qualifier(q2), .side_two_data_in(36'h0),
    .side_two_data_out(d2), .side_two_data_oe(), .endian_timing_select(ets), .narrow_bus_select(nb),
    .byte_width_select(bw), .near_full_threshold(4'h2), .near_empty_threshold(4'h1),
    .full_or_space_flag(fos), .near_full_flag_n(nfn), .empty_or_valid_flag(evf), .near_empty_flag_n(nen));
  dcf_reader u_rd (.clk(clk), .rst_n(rst_n), .std(std), .want(want), .flag(evf), .data(d2),
    .select_n(s2n), .qualifier(q2), .got(got), .q(rq));
  always #10 clk = ~clk;
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // straps are set during reset, then ets turns to the timing level after the first edge
  task automatic start(input logic [3:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    nb <= c[3];
    bw <= c[2];
    ets <= c[1];
    std <= c[0];
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ets <= c[0];
    repeat (4) @(posedge clk);
  endtask : start
  task automatic wr(input logic [35:0] d, input int k);
    for (int i = 0; i < k; i++)
    begin
      @(posedge clk);
      s1n <= 1'b0;
      q1 <= 1'b1;
      d1 <= d + 36'(i);
    end
    @(posedge clk);
    s1n <= 1'b1;
    q1 <= 1'b0;
    d1 <= ~d1;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [35:0] e);
    int t = 0;
    @(posedge clk);
    want <= 1'b1;
    @(posedge clk);
    want <= 1'b0;
    while (got !== 1'b1 && t < 200)
    begin
      @(negedge clk);
      t++;
    end
    chk(got, 1'b1);
    chk(rq, e);
  endtask : rd
  function automatic logic [35:0] lane(input int k, input logic big);
    int s;
    s = big ? (n - 1 - k) : k;
    return (W >> (s * (36 / n))) & ((36'h1 << (36 / n)) - 36'h1);
  endfunction : lane
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // fill to refusal in long mode, then walk lane orders per width
  initial
  begin
    for (int c = 0; c < 4; c++)
    begin
      start(CFG[c]);
      n = CFG[c][3] ? (CFG[c][2] ? 4 : 2) : 1;
      if (c == 0)
      begin
        wr(36'hA00, 5);
        chk(nfn, 1'b1);
        // the output stage adds one place, so the tenth word is the refused one
        wr(36'hA05, 5);
        chk(fos, 1'b0);
        chk(nfn, 1'b0);
        repeat (8) @(negedge clk);
        chk(nen, 1'b1);
        chk(evf, 1'b1);
        for (int i = 0; i < 9; i++)
          rd(36'hA00 + 36'(i));
        repeat (12) @(negedge clk);
        chk(evf, 1'b0);
        chk(nen, 1'b0);
        chk(fos, 1'b1);
      end
      else
      begin
        wr(W, 1);
        for (int k = 0; k < n; k++)
          rd(lane(k, CFG[c][1]));
      end
      $display("test %0d done", c);
    end
    test_done();
  end
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      test_done();
    end
  end
endmodule : tb_top
`default_nettype wire
